// ---- rtl/bcdclk_top.sv ----
// BCD calendar clock with AHB-Lite register slave.
// Assumes one 20 MHz clock, single-word transfers, always-ready master.

`timescale 1ns/1ns
`default_nettype none

module bcdclk_top
  import bcdclk_pkg::*;
#(
  // Clock cycles per second tick
  parameter int unsigned TICK_DIV = SEC_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic tick_irq
);

  bcdclk_state_s s_q;
  bcdclk_state_s s_d;

  // ---------------------------------------------------------------
  // BCD helpers
  // ---------------------------------------------------------------
  // Add one to a two-digit BCD value, carry from units to tens
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == DIG_NINE) begin
      r[3:0] = DIG_ZERO;
      r[7:4] = v[7:4] + DIG_ONE;
    end else begin
      r[3:0] = v[3:0] + DIG_ONE;
    end
    return r;
  endfunction

  // Last date of the current month, leap year when year divisible by 4
  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    logic [7:0] r;
    leap = (yr[4] == 1'b0) ? (yr[1:0] == 2'b00) : (yr[1:0] == 2'b10);
    r = BCD_31;
    if (mon == BCD_FEB) begin
      r = leap ? BCD_29 : BCD_28;
    end else if (mon == BCD_APR || mon == BCD_JUN || mon == BCD_SEP || mon == BCD_NOV) begin
      r = BCD_30;
    end
    return r;
  endfunction

  // Register read mux
  function automatic logic [31:0] read_reg(input bcdclk_state_s st, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      ADDR_SECONDS: begin
        r[6:0] = st.tm.sec[6:0];
        r[BUSY_BIT] = (st.upd != 2'h0);
      end
      ADDR_MINUTES: r[6:0] = st.tm.min[6:0];
      ADDR_HOURS: begin
        r[5:0] = st.tm.hour[5:0];
        r[HFMT_BIT] = st.hfmt;
      end
      ADDR_WEEKDAY: r[2:0] = st.tm.wday;
      ADDR_DATE: r[5:0] = st.tm.date[5:0];
      ADDR_MONTH: r[4:0] = st.tm.mon[4:0];
      ADDR_YEAR: r[7:0] = st.tm.year;
      ADDR_CONTROL: r[HFMT_BIT] = st.hfmt;
      ADDR_GUARD: r[GUARD_BIT] = st.guard;
      ADDR_TICK_EN: r[TICK_EN_BIT] = st.tick_en;
      ADDR_FLAGS: r[TICK_FLAG_BIT] = st.flag;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic tick;
  logic roll_min;
  logic roll_hour;
  logic roll_day;
  logic roll_mon;
  logic roll_year;
  logic wr_hit;
  logic tm_wr_ok;
  logic [7:0] wb;

  always_comb begin
    s_d = s_q;
    tick = 1'b0;
    roll_min = 1'b0;
    roll_hour = 1'b0;
    roll_day = 1'b0;
    roll_mon = 1'b0;
    roll_year = 1'b0;
    wb = hwdata[7:0];
    wr_hit = s_q.ap_valid && s_q.ap_write;
    tm_wr_ok = s_q.guard;

    // Busy window countdown
    if (s_q.upd != 2'h0) begin
      s_d.upd = s_q.upd - 2'h1;
    end

    // One-second prescaler
    if (s_q.div == 25'(TICK_DIV - 1)) begin
      s_d.div = '0;
      tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 25'h1;
    end

    // Calendar advance
    if (tick) begin
      s_d.upd = 2'(UPD_CYCLES);
      if (s_q.tm.sec[6:0] == {DIG_FIVE[2:0], DIG_NINE}) begin
        s_d.tm.sec = '0;
        roll_min = 1'b1;
      end else begin
        s_d.tm.sec = bcd_inc(s_q.tm.sec);
      end
      if (roll_min) begin
        if (s_q.tm.min[6:0] == {DIG_FIVE[2:0], DIG_NINE}) begin
          s_d.tm.min = '0;
          roll_hour = 1'b1;
        end else begin
          s_d.tm.min = bcd_inc(s_q.tm.min);
        end
      end
      if (roll_hour) begin
        if (s_q.tm.hour == BCD_23) begin
          s_d.tm.hour = '0;
          roll_day = 1'b1;
        end else begin
          s_d.tm.hour = bcd_inc(s_q.tm.hour);
        end
      end
      if (roll_day) begin
        s_d.tm.wday = (s_q.tm.wday >= WK_SAT) ? WK_SUN : s_q.tm.wday + 3'h1;
        if (s_q.tm.date >= month_last(s_q.tm.mon, s_q.tm.year)) begin
          s_d.tm.date = {DIG_ZERO, DIG_ONE};
          roll_mon = 1'b1;
        end else begin
          s_d.tm.date = bcd_inc(s_q.tm.date);
        end
      end
      if (roll_mon) begin
        if (s_q.tm.mon >= BCD_DEC) begin
          s_d.tm.mon = {DIG_ZERO, DIG_ONE};
          roll_year = 1'b1;
        end else begin
          s_d.tm.mon = bcd_inc(s_q.tm.mon);
        end
      end
      if (roll_year) begin
        s_d.tm.year = (s_q.tm.year == BCD_99) ? 8'h00 : bcd_inc(s_q.tm.year);
      end
    end

    // Register writes in the data phase
    if (wr_hit) begin
      unique case (s_q.ap_addr)
        ADDR_SECONDS: if (tm_wr_ok) begin
          s_d.tm.sec = {1'b0, wb[6:0]};
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_MINUTES: if (tm_wr_ok) begin
          s_d.tm.min = {1'b0, wb[6:0]};
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_HOURS: if (tm_wr_ok) begin
          s_d.tm.hour = {2'b00, wb[5:0]};
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_WEEKDAY: if (tm_wr_ok) begin
          s_d.tm.wday = wb[2:0];
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_DATE: if (tm_wr_ok) begin
          s_d.tm.date = {2'b00, wb[5:0]};
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_MONTH: if (tm_wr_ok) begin
          s_d.tm.mon = {3'b000, wb[4:0]};
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_YEAR: if (tm_wr_ok) begin
          s_d.tm.year = wb;
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_CONTROL: begin
          s_d.hfmt = wb[HFMT_BIT];
          s_d.upd = 2'(UPD_CYCLES);
        end
        ADDR_GUARD: s_d.guard = wb[GUARD_BIT];
        ADDR_TICK_EN: s_d.tick_en = wb[TICK_EN_BIT];
        ADDR_FLAGS: if (!wb[TICK_FLAG_BIT]) begin
          s_d.flag = 1'b0;
        end
        default: s_d.flag = s_d.flag;
      endcase
    end

    // Tick sets the flag, set wins over a clear
    if (tick) begin
      s_d.flag = 1'b1;
    end

    // Address phase capture and read data
    s_d.ap_valid = hsel && hready && (htrans == HTRANS_NONSEQ);
    s_d.ap_write = hwrite;
    s_d.ap_addr = haddr[7:0];
    if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite) begin
      s_d.rdata = read_reg(s_q, haddr[7:0]);
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
      s_q.tm.wday <= WK_RESET;
      s_q.tm.date <= {DIG_ZERO, DIG_ONE};
      s_q.tm.mon <= {DIG_ZERO, DIG_ONE};
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign tick_irq = s_q.flag && s_q.tick_en;

endmodule

`default_nettype wire

// ---- rtl/bcdclk_pkg.sv ----
// Constants, register map and carrier types of the BCD calendar clock.
// Assumes a single 20 MHz bus clock; the second tick is derived from it.

package bcdclk_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_HZ = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ / TICK_HZ;
  localparam int unsigned UPD_CYCLES = 2;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SECONDS = 8'h00;
  localparam logic [7:0] ADDR_MINUTES = 8'h04;
  localparam logic [7:0] ADDR_HOURS = 8'h08;
  localparam logic [7:0] ADDR_WEEKDAY = 8'h0c;
  localparam logic [7:0] ADDR_DATE = 8'h10;
  localparam logic [7:0] ADDR_MONTH = 8'h14;
  localparam logic [7:0] ADDR_YEAR = 8'h18;
  localparam logic [7:0] ADDR_CONTROL = 8'h1c;
  localparam logic [7:0] ADDR_GUARD = 8'h20;
  localparam logic [7:0] ADDR_TICK_EN = 8'h24;
  localparam logic [7:0] ADDR_FLAGS = 8'h28;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned BUSY_BIT = 7;
  localparam int unsigned GUARD_BIT = 7;
  localparam int unsigned TICK_EN_BIT = 2;
  localparam int unsigned TICK_FLAG_BIT = 1;
  localparam int unsigned HFMT_BIT = 6;

  // ---------------------------------------------------------------
  // Digit limits and reset values (Thu 01 Jan, year 00, 00:00:00)
  // ---------------------------------------------------------------
  localparam logic [3:0] DIG_NINE = 4'h9;
  localparam logic [3:0] DIG_ZERO = 4'h0;
  localparam logic [3:0] DIG_ONE = 4'h1;
  localparam logic [3:0] DIG_TWO = 4'h2;
  localparam logic [3:0] DIG_THREE = 4'h3;
  localparam logic [3:0] DIG_FIVE = 4'h5;
  localparam logic [2:0] WK_SAT = 3'h6;
  localparam logic [2:0] WK_SUN = 3'h0;
  localparam logic [2:0] WK_RESET = 3'h4;
  localparam logic [7:0] BCD_FEB = 8'h02;
  localparam logic [7:0] BCD_APR = 8'h04;
  localparam logic [7:0] BCD_JUN = 8'h06;
  localparam logic [7:0] BCD_SEP = 8'h09;
  localparam logic [7:0] BCD_NOV = 8'h11;
  localparam logic [7:0] BCD_DEC = 8'h12;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_99 = 8'h99;

  // ---------------------------------------------------------------
  // AHB-Lite codes
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] year;
  } bcdclk_time_s;

  typedef struct packed {
    logic [24:0] div;
    logic [1:0] upd;
    bcdclk_time_s tm;
    logic hfmt;
    logic guard;
    logic tick_en;
    logic flag;
    logic ap_valid;
    logic ap_write;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
  } bcdclk_state_s;

endpackage

// ---- test/bcdclk_asserts.sv ----
// Bus-side assertions for the BCD calendar clock.
// Assumes hready is tied to hreadyout.
`timescale 1ns/1ns
`default_nettype none
module bcdclk_asserts
  import bcdclk_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tick_irq
);
  logic dv_q;
  logic en_q;
  logic dw_q;
  logic [7:0] da_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Data phase tracking and enable mirror
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      dv_q <= hsel && hready && htrans == HTRANS_NONSEQ;
      if (dv_q && dw_q && da_q == ADDR_TICK_EN) en_q <= hwdata[TICK_EN_BIT];
    end
  end
  // Address and direction of the data phase
  always_ff @(posedge hclk) begin
    dw_q <= hwrite;
    da_q <= haddr[7:0];
  end
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_upper_zero: assert property (dv_q && !dw_q |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (dv_q && !dw_q && (da_q > ADDR_FLAGS || da_q[1:0] != 2'h0)
    |-> hrdata == 32'h0) else $error("unmapped read not zero");
  a_rdata_stand: assert property (!(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite)
    |=> $stable(hrdata)) else $error("hrdata moved without read");
  a_irq_masked: assert property (!en_q |-> !tick_irq) else $error("irq while disabled");
  a_month_width: assert property (dv_q && !dw_q && da_q == ADDR_MONTH |-> hrdata[7:5] == 3'h0)
    else $error("month tens too wide");
  a_wday_width: assert property (dv_q && !dw_q && da_q == ADDR_WEEKDAY |-> hrdata[7:3] == 5'h0)
    else $error("weekday too wide");
  a_busy_ctrl: assert property (dv_q && dw_q && da_q == ADDR_CONTROL ##2 (hsel && !hwrite
    && htrans == HTRANS_NONSEQ && haddr[7:0] == ADDR_SECONDS) |=> hrdata[BUSY_BIT])
    else $error("busy not shown after control write");
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking bench for the BCD calendar clock register slave.
// Assumes a shortened second tick, none before the second reset.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import bcdclk_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic tick_irq;
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 81252;
  logic [31:0] r;
  logic [31:0] t;
  logic [7:0] v [7];
  logic [7:0] cv [7] = '{8'h59, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};
  logic [7:0] rv [11] = '{8'h0, 8'h0, 8'h0, 8'h4, 8'h1, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
  int tl [7] = '{6, 6, 2, 7, 3, 1, 10};
  // Short second so ticks fit the run; first tick well after the second reset
  localparam int unsigned TB_TICK = 600;
  int f [7];
  logic [55:0] cc [12] = '{56'h59592306311299, 56'h59592303280223, 56'h59592305280224,
    56'h59592301290200, 56'h59592302300419, 56'h59590900150637, 56'h09000000010100,
    56'h59591904310109, 56'h59592304311209, 56'h59592300310150, 56'h59592302280212, 56'h59592303300905};

  always #25 hclk = ~hclk;

  bcdclk_top #(.TICK_DIV(TB_TICK)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tick_irq(tick_irq));

  // ----------------------------------------
  // Bus tasks and checking
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h0);
    chk(r, {24'h0, e});
  endtask

  // Days in a month, every fourth year a leap year
  function automatic int dim(input int m, input int y);
    if (m == 2) return (y % 4 == 0) ? 29 : 28;
    if (m == 4 || m == 6 || m == 9 || m == 11) return 30;
    return 31;
  endfunction

  // Two-digit BCD to binary and back
  function automatic int bin(input logic [7:0] b);
    return b[7:4] * 10 + b[3:0];
  endfunction

  function automatic logic [7:0] bcd(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction

  // Expected calendar one second later
  function automatic void step();
    f[0]++;
    if (f[0] == 60) begin
      f[0] = 0;
      f[1]++;
    end
    if (f[1] == 60) begin
      f[1] = 0;
      f[2]++;
    end
    if (f[2] == 24) begin
      f[2] = 0;
      f[3] = (f[3] + 1) % 7;
      f[4]++;
    end
    if (f[4] > dim(f[5], f[6])) begin
      f[4] = 1;
      f[5]++;
    end
    if (f[5] == 13) begin
      f[5] = 1;
      f[6] = (f[6] + 1) % 100;
    end
  endfunction

  // Poll the tick flag, then the busy bit, as the handler does
  task automatic wait_tick;
    r = 32'h0;
    while (r[TICK_FLAG_BIT] !== 1'b1) xfer(1'b0, ADDR_FLAGS, 8'h0);
    r = 32'h80;
    while (r[BUSY_BIT] !== 1'b0) xfer(1'b0, ADDR_SECONDS, 8'h0);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(8'(i * 4), rv[i]);
    $display("test reset values done");
    xfer(1'b1, ADDR_MINUTES, 8'h37);
    rd(ADDR_MINUTES, 8'h0);
    xfer(1'b1, ADDR_GUARD, 8'h80);
    rd(ADDR_GUARD, 8'h80);
    for (int k = 0; k < 5; k++) begin
      for (int i = 0; i < 7; i++) begin
        t = $random(seed);
        v[i] = (k == 0) ? cv[i] : (i == 3) ? 8'(t % 7) : 8'((t / 16) % tl[i] * 16 + t % 9 + 1);
        xfer(1'b1, 8'(i * 4), v[i]);
      end
      rd(8'h2c, 8'h0);
      rd(8'hfe, 8'h0);
      for (int i = 0; i < 7; i++) rd(8'(i * 4), v[i]);
    end
    $display("test field write back done");
    xfer(1'b1, ADDR_CONTROL, 8'h40);
    xfer(1'b0, ADDR_SECONDS, 8'h0);
    chk({31'h0, r[BUSY_BIT]}, 32'h1);
    xfer(1'b0, ADDR_SECONDS, 8'h0);
    chk({31'h0, r[BUSY_BIT]}, 32'h0);
    xfer(1'b1, ADDR_SECONDS, 8'hd9);
    rd(8'h2c, 8'h0);
    rd(ADDR_SECONDS, 8'h59);
    $display("test busy done");
    xfer(1'b1, ADDR_TICK_EN, 8'h04);
    rd(ADDR_TICK_EN, 8'h04);
    xfer(1'b1, ADDR_FLAGS, 8'h02);
    rd(ADDR_FLAGS, 8'h0);
    xfer(1'b1, ADDR_FLAGS, 8'h00);
    rd(ADDR_FLAGS, 8'h0);
    chk({31'h0, tick_irq}, 32'h0);
    $display("test flag done");
    xfer(1'b1, ADDR_GUARD, 8'h00);
    xfer(1'b1, ADDR_YEAR, 8'h11);
    rd(ADDR_YEAR, v[6]);
    xfer(1'b1, 8'h2c, 8'h55);
    rd(8'h2c, 8'h0);
    $display("test guard done");
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_HOURS, 8'h0);
    rd(ADDR_WEEKDAY, 8'h4);
    $display("test second reset done");
    xfer(1'b1, ADDR_GUARD, 8'h80);
    xfer(1'b1, ADDR_TICK_EN, 8'h04);
    for (int k = 0; k < 16; k++) begin
      t = $random(seed);
      for (int i = 0; i < 7; i++) f[i] = bin(cc[k % 12][55 - 8 * i -: 8]);
      if (k >= 12) begin
        f[0] = t % 60;
        f[1] = (t >> 8) % 60;
        f[2] = (t >> 16) % 24;
        f[3] = (t >> 24) % 7;
        t = $random(seed);
        f[5] = t % 12 + 1;
        f[6] = (t >> 8) % 100;
        f[4] = (t >> 16) % dim(f[5], f[6]) + 1;
      end
      for (int i = 0; i < 7; i++) xfer(1'b1, 8'(i * 4), bcd(f[i]));
      step();
      wait_tick();
      chk({31'h0, tick_irq}, 32'h1);
      xfer(1'b1, ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, 8'h0);
      chk({31'h0, tick_irq}, 32'h0);
      for (int i = 0; i < 7; i++) rd(8'(i * 4), bcd(f[i]));
    end
    $display("test tick roll done");
    xfer(1'b1, ADDR_TICK_EN, 8'h00);
    wait_tick();
    chk({31'h0, tick_irq}, 32'h0);
    $display("test tick mask done");
    results();
  end

  // Watchdog against a hung bus; about 11k cycles expected (17 ticks of 600 plus traffic)
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    results();
  end
endmodule

bind bcdclk_top bcdclk_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tick_irq(tick_irq));
`default_nettype wire
